// [rtl/synth_config_latches.sv]
// Contract
// - Host shifts 24 bits MSB first; load strobe rise copies word.
// - Lowest two bits route word: control, reference, feedback, test.
// - Word ending in 00 is stored as the control word.
// - First control write after power-up leaves power-down.
// - Leaving power-down with feedback unchanged reuses the band.
// - Top two control bits pick the prescaler ratio.
// - Arm set with mode clear powers down right after the latch.
// - Arm and mode set power down on second divider edge.
// - Chip-on low disables the device regardless of programming.
// - Power-down loads counters, three-states pump, clears lock.
// - Serial register keeps shifting and latching while down.
// - Two three-bit fields hold pump currents one and two.
// - Two-bit field picks one of four output power levels.
// - Mute-until-locked keeps output stage off until lock.
// - Pump gain 1 uses current two, 0 uses current one.
// - Pump gain holds its last write from either word.
// - Pump three-state bit set puts pump in high impedance.
// - Polarity bit 1 positive, 0 inverted.
// - Three-bit field selects monitor output source.
// - Counter reset bit holds reference and feedback counters.
// - Two-bit field sets oscillator core current.
// - Lock after three or five good cycles, by precision bit.
`include "synth_defines.svh"

module synth_config_latches
  import synth_pkg::*;
#(
  parameter int WORD_W = `SCL_WORD_W
) (
  // Clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               rst_b_in,
  // Serial link
  input  wire logic               serial_clk_in,
  input  wire logic               serial_data_in,
  input  wire logic               load_strobe_in,
  // Device pins and loop status
  input  wire logic               chip_on_in,
  input  wire logic               ref_div_in,
  input  wire logic               phase_err_small_in,
  input  wire logic               phase_err_large_in,
  // Stored words
  output control_word_type        control_word_out,
  output reference_word_type      reference_word_out,
  output feedback_word_type       feedback_word_out,
  output logic [WORD_W-1:0]       test_word_out,
  // Loop settings
  output logic [1:0]              prescaler_sel_out,
  output logic                    pump_gain_select_out,
  output logic [2:0]              pump_current_out,
  output logic                    pump_tristate_out,
  output logic                    detector_polarity_out,
  output logic [1:0]              core_current_out,
  output logic                    counters_load_out,
  // Output stage and monitor
  output logic [1:0]              output_power_out,
  output logic                    output_enable_out,
  output logic                    monitor_output_pin_out,
  // Power and lock status
  output logic                    powered_down_out,
  output logic                    ref_buffer_en_out,
  output logic                    lock_detect_out,
  output logic                    band_select_req_out,
  output logic                    band_stale_out
);

  // ****************************************************************
  // Link domain: reset crossing and input shift register
  // ****************************************************************
  logic              link_rst_meta_q;
  logic              link_rst_b_q;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;

  always_ff @(posedge serial_clk_in) begin
    link_rst_meta_q <= rst_b_in;
    link_rst_b_q    <= link_rst_meta_q;
  end

  // shift never gated by power state
  always_comb begin
    shift_d = {shift_q[WORD_W-2:0], serial_data_in};
  end

  // MSB first, one bit per rising edge
  always_ff @(posedge serial_clk_in) begin
    if (!link_rst_b_q) begin
      shift_q <= `SCL_SHIFT_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ****************************************************************
  // Pin synchronisers into the reference clock domain
  // ****************************************************************
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic [4:0] pin_raw;
  logic       load_prev_q;
  logic       ref_prev_q;
  logic       load_rise;
  logic       ref_rise;
  logic       ce_on;

  assign pin_raw = {phase_err_large_in, phase_err_small_in, ref_div_in,
                    chip_on_in, load_strobe_in};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin_sync
      always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      load_prev_q <= 1'b0;
      ref_prev_q  <= 1'b0;
    end else begin
      load_prev_q <= pin_sync_q[0];
      ref_prev_q  <= pin_sync_q[2];
    end
  end

  assign load_rise = pin_sync_q[0] & ~load_prev_q;
  assign ref_rise  = pin_sync_q[2] & ~ref_prev_q;
  assign ce_on     = pin_sync_q[1];

  // ****************************************************************
  // Word capture and routing
  // ****************************************************************
  // The shift register is not gated by the strobe; the host keeps the serial
  // clock idle while it is high, so the word is stable when the synchronised
  // strobe edge samples it.
  logic [WORD_W-1:0]  word_in;
  logic [1:0]         word_sel;
  logic               wr_control;
  logic               wr_reference;
  logic               wr_feedback;
  logic               wr_test;
  control_word_type   new_control;
  feedback_word_type  new_feedback;
  control_word_type   control_q;
  reference_word_type reference_q;
  feedback_word_type  feedback_q;
  logic [WORD_W-1:0]  test_q;

  assign word_in      = shift_q;
  assign word_sel     = word_in[1:0];
  assign new_control  = word_in;
  assign new_feedback = word_in;

  // two lowest bits pick the latch
  assign wr_reference = load_rise & (word_sel == `SCL_SEL_REFDIV);
  assign wr_feedback  = load_rise & (word_sel == `SCL_SEL_FBDIV);
  assign wr_test      = load_rise & (word_sel == `SCL_SEL_TEST);
  assign wr_control   = load_rise & (word_sel == `SCL_SEL_CONTROL);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      control_q   <= `SCL_WORD_RESET;
      reference_q <= `SCL_WORD_RESET;
      feedback_q  <= `SCL_WORD_RESET;
      test_q      <= `SCL_WORD_RESET;
    end else begin
      if (wr_control) begin
        control_q <= word_in;
      end
      if (wr_reference) begin
        reference_q <= word_in;
      end
      if (wr_feedback) begin
        feedback_q <= word_in;
      end
      if (wr_test) begin
        test_q <= word_in;
      end
    end
  end

  // ****************************************************************
  // Shared pump gain bit
  // ****************************************************************
  logic gain_q;

  // last writer of either word wins
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      gain_q <= 1'b0;
    end else if (wr_control) begin
      gain_q <= new_control.pump_gain_select;
    end else if (wr_feedback) begin
      gain_q <= new_feedback.pump_gain_select;
    end
  end

  // ****************************************************************
  // Power-down control
  // ****************************************************************
  soft_pd_state_type soft_q;
  logic [1:0]        edge_cnt_q;
  logic              initial_pd_q;
  logic              powered_down;

  // held down until first control write
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      initial_pd_q <= 1'b1;
    end else if (wr_control) begin
      initial_pd_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      soft_q     <= SOFT_RUN;
      edge_cnt_q <= 2'h0;
    end else if (wr_control) begin
      edge_cnt_q <= 2'h0;
      if (!new_control.power_down_arm) begin
        // arm clear runs whatever the mode bit
        soft_q <= SOFT_RUN;
      end else if (!new_control.power_down_mode) begin
        // asynchronous mode goes down at once
        soft_q <= SOFT_DOWN;
      end else if (soft_q != SOFT_DOWN) begin
        soft_q <= SOFT_WAIT;
      end
    end else begin
      case (soft_q)
        SOFT_RUN: begin
          edge_cnt_q <= 2'h0;
        end
        SOFT_WAIT: begin
          if (ref_rise) begin
            if (edge_cnt_q == `SCL_PD_SYNC_EDGES - 2'h1) begin
              soft_q <= SOFT_DOWN;
            end
            edge_cnt_q <= edge_cnt_q + 2'h1;
          end
        end
        SOFT_DOWN: begin
          edge_cnt_q <= 2'h0;
        end
        default: begin
          soft_q <= SOFT_RUN;
        end
      endcase
    end
  end

  assign powered_down = initial_pd_q | (soft_q == SOFT_DOWN) | ~ce_on;

  // ****************************************************************
  // Band selection bookkeeping
  // ****************************************************************
  logic band_req_q;
  logic band_stale_q;

  // no new band search on power-up itself
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      band_req_q   <= 1'b0;
      band_stale_q <= 1'b0;
    end else begin
      band_req_q <= wr_feedback & ~powered_down;
      if (wr_feedback) begin
        band_stale_q <= powered_down;
      end
    end
  end

  // ****************************************************************
  // Digital lock detect
  // ****************************************************************
  logic [`SCL_LOCK_CNT_W-1:0] good_cnt_q;
  logic [`SCL_LOCK_CNT_W-1:0] good_need;
  logic                       lock_q;

  assign good_need = reference_q.lock_precision ? `SCL_LOCK_CNT_HIGH
                                                : `SCL_LOCK_CNT_LOW;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      good_cnt_q <= '0;
      lock_q     <= 1'b0;
    end else if (powered_down) begin
      good_cnt_q <= '0;
      lock_q     <= 1'b0;
    end else if (ref_rise) begin
      if (pin_sync_q[3]) begin
        if (good_cnt_q + 1'b1 >= good_need) begin
          lock_q <= 1'b1;
        end
        if (good_cnt_q < good_need) begin
          good_cnt_q <= good_cnt_q + 1'b1;
        end
      end else begin
        good_cnt_q <= '0;
      end
      if (pin_sync_q[4]) begin
        lock_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  logic [7:0] monitor_src;

  assign monitor_src = {ce_on, 1'b1, gain_q, powered_down,
                        band_stale_q, pin_sync_q[2], lock_q, 1'b0};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      control_word_out      <= `SCL_WORD_RESET;
      reference_word_out    <= `SCL_WORD_RESET;
      feedback_word_out     <= `SCL_WORD_RESET;
      test_word_out         <= `SCL_WORD_RESET;
      prescaler_sel_out     <= 2'h0;
      pump_gain_select_out  <= 1'b0;
      pump_current_out      <= 3'h0;
      pump_tristate_out     <= 1'b1;
      detector_polarity_out <= 1'b0;
      core_current_out      <= 2'h0;
      counters_load_out     <= 1'b1;
      output_power_out      <= 2'h0;
      output_enable_out     <= 1'b0;
      monitor_output_pin_out <= 1'b0;
      powered_down_out      <= 1'b1;
      ref_buffer_en_out     <= 1'b0;
      lock_detect_out       <= 1'b0;
      band_select_req_out   <= 1'b0;
      band_stale_out        <= 1'b0;
    end else begin
      control_word_out      <= control_q;
      reference_word_out    <= reference_q;
      feedback_word_out     <= feedback_q;
      test_word_out         <= test_q;
      prescaler_sel_out     <= control_q.prescaler_sel;
      pump_gain_select_out  <= gain_q;
      pump_current_out      <= gain_q ? control_q.pump_current_b
                                      : control_q.pump_current_a;
      pump_tristate_out     <= control_q.pump_tristate | powered_down;
      detector_polarity_out <= control_q.detector_polarity;
      core_current_out      <= control_q.core_current;
      counters_load_out     <= control_q.counter_hold_reset | powered_down;
      output_power_out      <= control_q.output_power;
      output_enable_out     <= ~powered_down &
                               (~control_q.mute_until_locked | lock_q);
      monitor_output_pin_out <= monitor_src[control_q.monitor_select];
      powered_down_out      <= powered_down;
      ref_buffer_en_out     <= ~powered_down;
      lock_detect_out       <= lock_q;
      band_select_req_out   <= band_req_q;
      band_stale_out        <= band_stale_q;
    end
  end

endmodule : synth_config_latches

// [common/synth_defines.svh]
`ifndef SYNTH_CONFIG_DEFINES_SVH
`define SYNTH_CONFIG_DEFINES_SVH

// ****************************************************************
// Serial word format
// ****************************************************************
`define SCL_WORD_W        24
`define SCL_SEL_CONTROL   2'h0
`define SCL_SEL_REFDIV    2'h1
`define SCL_SEL_FBDIV     2'h2
`define SCL_SEL_TEST      2'h3

// ****************************************************************
// Reset values of the stored words
// ****************************************************************
`define SCL_WORD_RESET    24'h000000
`define SCL_SHIFT_RESET   24'h000000

// ****************************************************************
// Power-down and lock timing, in reference divider edges
// ****************************************************************
`define SCL_PD_SYNC_EDGES 2'h2
`define SCL_LOCK_CNT_LOW  3'h3
`define SCL_LOCK_CNT_HIGH 3'h5
`define SCL_LOCK_CNT_W    3

`endif

// [common/synth_pkg.sv]
package synth_pkg;

  // ****************************************************************
  // Stored word layouts, most significant field first
  // ****************************************************************
  typedef struct packed {
    logic [1:0] prescaler_sel;
    logic       power_down_mode;
    logic       power_down_arm;
    logic [2:0] pump_current_b;
    logic [2:0] pump_current_a;
    logic [1:0] output_power;
    logic       mute_until_locked;
    logic       pump_gain_select;
    logic       pump_tristate;
    logic       detector_polarity;
    logic [2:0] monitor_select;
    logic       counter_hold_reset;
    logic [1:0] core_current;
    logic [1:0] word_select;
  } control_word_type;

  typedef struct packed {
    logic        halved_prescaler_input;
    logic        output_halving;
    logic        pump_gain_select;
    logic [12:0] b_count;
    logic        spare_bit;
    logic [4:0]  a_count;
    logic [1:0]  word_select;
  } feedback_word_type;

  typedef struct packed {
    logic [1:0]  spare_bits;
    logic [1:0]  band_clock_divider;
    logic        factory_test_bit;
    logic        lock_precision;
    logic [1:0]  pulse_width;
    logic [13:0] r_count;
    logic [1:0]  word_select;
  } reference_word_type;

  // ****************************************************************
  // Programmed power-down sequencing
  // ****************************************************************
  typedef enum logic [1:0] {
    SOFT_RUN,
    SOFT_WAIT,
    SOFT_DOWN
  } soft_pd_state_type;

endpackage : synth_pkg

// [testbench/synth_config_latches_assertions.sv]
module synth_config_latches_assertions
  import synth_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk_in,
  input wire logic             rst_b_in,
  // Observed pins
  input wire logic             chip_on_in,
  input wire control_word_type control_word_out,
  input wire logic [1:0]       prescaler_sel_out,
  input wire logic             pump_gain_select_out,
  input wire logic [2:0]       pump_current_out,
  input wire logic             pump_tristate_out,
  input wire logic             detector_polarity_out,
  input wire logic [1:0]       core_current_out,
  input wire logic             counters_load_out,
  input wire logic [1:0]       output_power_out,
  input wire logic             output_enable_out,
  input wire logic             powered_down_out,
  input wire logic             ref_buffer_en_out,
  input wire logic             lock_detect_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_down;
    powered_down_out [*2];
  endsequence
  sequence s_word_still;
    $stable(control_word_out) [*2];
  endsequence

  property p_down_pump;
    s_down |-> pump_tristate_out && counters_load_out;
  endproperty
  a_down_pump: assert property (p_down_pump)
    else $error("pump or counters active while powered down");
  property p_down_quiet;
    s_down |-> !lock_detect_out && !output_enable_out && !ref_buffer_en_out;
  endproperty
  a_down_quiet: assert property (p_down_quiet)
    else $error("lock, output or buffer active while powered down");
  property p_chip_off;
    (!chip_on_in) [*5] |-> powered_down_out;
  endproperty
  a_chip_off: assert property (p_chip_off)
    else $error("chip-on low did not power down");
  property p_async;
    (control_word_out.power_down_arm &&
     !control_word_out.power_down_mode) [*2] |-> powered_down_out;
  endproperty
  a_async: assert property (p_async)
    else $error("arm without mode did not power down");
  property p_fields;
    s_word_still |->
      prescaler_sel_out == control_word_out.prescaler_sel &&
      detector_polarity_out == control_word_out.detector_polarity &&
      output_power_out == control_word_out.output_power &&
      core_current_out == control_word_out.core_current;
  endproperty
  a_fields: assert property (p_fields)
    else $error("control fields not reflected");
  property p_gain;
    s_word_still ##0 $stable(pump_gain_select_out) [*2] |->
      pump_current_out == (pump_gain_select_out ?
        control_word_out.pump_current_b : control_word_out.pump_current_a);
  endproperty
  a_gain: assert property (p_gain)
    else $error("pump current does not follow gain");
  property p_hold;
    control_word_out.counter_hold_reset [*2] |-> counters_load_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter hold bit ignored");
  property p_pump_off;
    control_word_out.pump_tristate [*2] |-> pump_tristate_out;
  endproperty
  a_pump_off: assert property (p_pump_off)
    else $error("pump three-state bit ignored");
  property p_mute;
    (control_word_out.mute_until_locked && !lock_detect_out) [*2]
      |-> !output_enable_out;
  endproperty
  a_mute: assert property (p_mute)
    else $error("output on before lock while muted");
endmodule : synth_config_latches_assertions

bind synth_config_latches synth_config_latches_assertions i_chk (
  .ref_clk_in, .rst_b_in, .chip_on_in, .control_word_out,
  .prescaler_sel_out, .pump_gain_select_out, .pump_current_out,
  .pump_tristate_out, .detector_polarity_out, .core_current_out,
  .counters_load_out, .output_power_out, .output_enable_out,
  .powered_down_out, .ref_buffer_en_out, .lock_detect_out
);

// [testbench/serial_host_model.sv]
module serial_host_model (
  // Serial link
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic load_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_clk_out  = 1'b0;
    serial_data_out = 1'b0;
    load_strobe_out = 1'b0;
  end

  // Link-side reset needs a few edges
  task automatic link_wake();
    repeat (4) begin
      #3 serial_clk_out = 1'b1;
      #3 serial_clk_out = 1'b0;
    end
  endtask : link_wake

  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data_out = w[i];
      #3 serial_clk_out = 1'b1;
      #3 serial_clk_out = 1'b0;
    end
    // Released line must not keep the last bit
    serial_data_out = ~w[0];
    #3 load_strobe_out = 1'b1;
    #30 load_strobe_out = 1'b0;
    #20;
  endtask : send_word
endmodule : serial_host_model

// [testbench/synth_config_latches_bench.sv]
module synth_config_latches_bench
  import synth_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE_CYC = 120;
  logic ref_clk_in, rst_b_in, chip_on_in, ref_div_in;
  logic phase_err_small_in, phase_err_large_in;
  logic serial_clk_in, serial_data_in, load_strobe_in;
  control_word_type   control_word_out;
  reference_word_type reference_word_out;
  feedback_word_type  feedback_word_out;
  logic [23:0] test_word_out, c, f, r, t;
  logic [1:0]  prescaler_sel_out, core_current_out, output_power_out;
  logic [2:0]  pump_current_out;
  logic pump_gain_select_out, pump_tristate_out, detector_polarity_out;
  logic counters_load_out, output_enable_out, monitor_output_pin_out;
  logic powered_down_out, ref_buffer_en_out, lock_detect_out;
  logic band_select_req_out, band_stale_out;
  int   num_errors = 0;
  int   compares = 0;
  int   band_reqs = 0;

  serial_host_model i_host (.serial_clk_out(serial_clk_in),
    .serial_data_out(serial_data_in), .load_strobe_out(load_strobe_in));
  synth_config_latches i_dut (.ref_clk_in, .rst_b_in, .serial_clk_in,
    .serial_data_in, .load_strobe_in, .chip_on_in, .ref_div_in,
    .phase_err_small_in, .phase_err_large_in, .control_word_out,
    .reference_word_out, .feedback_word_out, .test_word_out,
    .prescaler_sel_out, .pump_gain_select_out, .pump_current_out,
    .pump_tristate_out, .detector_polarity_out, .core_current_out,
    .counters_load_out, .output_power_out, .output_enable_out,
    .monitor_output_pin_out, .powered_down_out, .ref_buffer_en_out,
    .lock_detect_out, .band_select_req_out, .band_stale_out);

  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // Count one-cycle band search requests away from the launching edge
  always @(negedge ref_clk_in) begin
    if (band_select_req_out === 1'b1) begin
      band_reqs++;
    end
  end

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(input string s, input logic [23:0] e, logic [23:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic wr(input logic [23:0] w);
    i_host.send_word(w);
    repeat (4) @(negedge ref_clk_in);
  endtask : wr

  task automatic pulses(input int n);
    repeat (n) begin
      ref_div_in = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      ref_div_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
    end
    repeat (4) @(negedge ref_clk_in);
  endtask : pulses

  function automatic logic [23:0] rnd_ctrl();
    logic [23:0] v;
    v = 24'($urandom);
    v[20] = 1'b0;
    v[1:0] = 2'h0;
    return v;
  endfunction : rnd_ctrl

  task automatic chk_pd(input logic d);
    chk("pd", 24'(d), 24'(powered_down_out));
    chk("tri", 24'(d), 24'(pump_tristate_out & d));
    chk("load", 24'(d), 24'(counters_load_out & d));
    chk("lock", 24'h0, 24'(lock_detect_out & d));
    chk("refbuf", 24'(!d), 24'(ref_buffer_en_out));
  endtask : chk_pd

  task automatic chk_ctrl(input logic [23:0] v);
    logic [2:0] s;
    logic [2:0] cur;
    logic       mon;
    s = v[7:5];
    cur = v[10] ? v[19:17] : v[16:14];
    mon = (s == 3'h5) ? v[10] : (s >= 3'h6);
    chk("ctrl", v, control_word_out);
    chk("psel", 24'(v[23:22]), 24'(prescaler_sel_out));
    chk("cur", 24'(cur), 24'(pump_current_out));
    chk("tri", 24'(v[9]), 24'(pump_tristate_out));
    chk("pol", 24'(v[8]), 24'(detector_polarity_out));
    chk("core", 24'(v[3:2]), 24'(core_current_out));
    chk("hold", 24'(v[4]), 24'(counters_load_out));
    chk("pwr", 24'(v[13:12]), 24'(output_power_out));
    chk("oe", 24'(!v[11]), 24'(output_enable_out));
    chk("mon", 24'(mon), 24'(monitor_output_pin_out));
    chk_pd(1'b0);
  endtask : chk_ctrl

  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    num_errors++;
    finish_test();
  end

  initial begin
    rst_b_in = 1'b0;
    chip_on_in = 1'b1;
    ref_div_in = 1'b0;
    phase_err_small_in = 1'b0;
    phase_err_large_in = 1'b0;
    void'($urandom(32'hb183));
    fork
      i_host.link_wake();
      repeat (10) @(negedge ref_clk_in);
    join
    rst_b_in = 1'b1;
    chk_pd(1'b1);
    // Link reset only lets go on serial edges after release
    i_host.link_wake();
    r = 24'($urandom) & 24'hfbfffc | 24'h1;
    wr(r);
    chk("ref", r, reference_word_out);
    chk_pd(1'b1);
    c = rnd_ctrl();
    wr(c);
    chk_ctrl(c);
    repeat (SETTLE_CYC) @(negedge ref_clk_in);
    f = 24'($urandom) & 24'hfffffc | 24'h2;
    f[21] = ~c[10];
    wr(f);
    chk("fb", f, feedback_word_out);
    chk("gain", 24'(f[21]), 24'(pump_gain_select_out));
    chk("breq", 24'h1, 24'(band_reqs));
    chk("stale", 24'h0, 24'(band_stale_out));
    t = 24'($urandom) | 24'h3;
    wr(t);
    chk("test", t, test_word_out);
    repeat (8) begin
      c = rnd_ctrl();
      wr(c);
      chk_ctrl(c);
    end
    c = rnd_ctrl();
    c[11] = 1'b1;
    c[4] = 1'b0;
    wr(c);
    phase_err_small_in = 1'b1;
    pulses(2);
    chk("lock", 24'h0, 24'(lock_detect_out));
    chk("oe", 24'h0, 24'(output_enable_out));
    pulses(1);
    chk("lock", 24'h1, 24'(lock_detect_out));
    chk("oe", 24'h1, 24'(output_enable_out));
    r[18] = 1'b1;
    wr(r);
    phase_err_small_in = 1'b0;
    phase_err_large_in = 1'b1;
    pulses(1);
    chk("lock", 24'h0, 24'(lock_detect_out));
    chk("oe", 24'h0, 24'(output_enable_out));
    phase_err_large_in = 1'b0;
    phase_err_small_in = 1'b1;
    pulses(4);
    chk("lock", 24'h0, 24'(lock_detect_out));
    pulses(1);
    chk("lock", 24'h1, 24'(lock_detect_out));
    c[21:20] = 2'h1;
    wr(c);
    chk_pd(1'b1);
    r[18] = 1'b0;
    wr(r);
    chk("ref", r, reference_word_out);
    wr(f);
    chk("stale", 24'h1, 24'(band_stale_out));
    chk("breq", 24'h1, 24'(band_reqs));
    c[21:20] = 2'h2;
    wr(c);
    chk_pd(1'b0);
    wr(f);
    chk("stale", 24'h0, 24'(band_stale_out));
    chk("breq", 24'h2, 24'(band_reqs));
    c[21:20] = 2'h3;
    wr(c);
    pulses(1);
    chk_pd(1'b0);
    pulses(1);
    chk_pd(1'b1);
    c[21:20] = 2'h0;
    wr(c);
    chk_pd(1'b0);
    chip_on_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk_pd(1'b1);
    chip_on_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    chk_pd(1'b0);
    chk("stale", 24'h0, 24'(band_stale_out));
    finish_test();
  end
endmodule : synth_config_latches_bench
